// ### hdl/gpio_irq_mask_control.sv
/*
 * Pin configuration, event masking, interrupt request and voltage write lock.
 * Assumes a byte register port from the serial interface core, one request per
 * cycle, and fault status levels from the regulator logic on the same clock.
 */
// Notes on behaviour
// RL1: Masked input events never raise interrupt request.
// RL2: Overcurrent masks block both interrupt and event.
// RL3: Thermal masks keep events off interrupt request.
// RL4: In-range masks keep range loss off interrupt.
// RL5: Lock bit blocks writes to voltage range.
// RL6: Regulator B ramps 10mV per selected interval.
// RL7: Regulator A uses same ramp encoding.
// RL8: Three-bit code selects global debounce time.
// RL9: Per-pin bit switches input debouncing.
// RL10: Type bit sets pin active polarity.
// RL11: Input 0 function: plain input or track.
// RL12: Pins 2,3: input, open-drain or push-pull.
// RL13: Output pins drive level from mode bit.
// RL14: Debounced change reported after stable time.
// RL15: Unmasked set event drives interrupt active.
// RL16: Host clears by write-back; late events delayed.
module gpio_irq_mask_control
    import gpio_irq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Write through to the locked voltage registers
    output logic volt_wr_en,
    output logic [8:0] volt_wr_addr,
    output logic [7:0] volt_wr_data,
    // Pins
    input wire logic [4:0] pin_in,
    output logic pin2_out,
    output logic pin2_oe,
    output logic pin3_out,
    output logic pin3_oe,
    output logic track_enable,
    // Fault status levels: ovc_b, ovc_a, crit, warn, good_b, good_a
    input wire logic [5:0] fault_status,
    // Ramp step pulses, 10 mV each
    output logic ramp_step_a,
    output logic ramp_step_b,
    // Interrupt request
    output logic interrupt_request_n
);
    logic [7:0] mask_a_q, mask_a_d, fault_mask_q, fault_mask_d, lock_ctrl_q, lock_ctrl_d;
    logic [7:0] in01_q, in01_d, pin23_q, pin23_d, in4_q, in4_d;
    logic [4:0] event_in_q, event_in_d;
    logic [5:0] event_fault_q, event_fault_d;
    logic [4:0] level_q, level_d;
    logic [5:0] fault_prev_q, fault_prev_d;
    logic [4:0] pend_in_q, pend_in_d;
    logic [5:0] pend_fault_q, pend_fault_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d, irq_n_q, irq_n_d;
    logic vwr_q, vwr_d;
    logic [8:0] vaddr_q, vaddr_d;
    logic [7:0] vdata_q, vdata_d;
    logic p2o_q, p2o_d, p2e_q, p2e_d, p3o_q, p3o_d, p3e_q, p3e_d, trk_q, trk_d;
    logic [15:0] ramp_cnt_q [2];
    logic [15:0] ramp_cnt_d [2];
    logic [1:0] step_q, step_d;
    logic [4:0] level_now;
    logic [23:0] deb_limit;
    pin_cfg_type cfg [5];

    // Cycle count of a time given in ns, at least one cycle
    function automatic logic [15:0] ns_to_cycles(input logic [1:0] code);
        int c;
        c = RAMP_NS[code] / NS_PER_CYCLE;
        if (c < 1) c = 1;
        return 16'(c);
    endfunction : ns_to_cycles

    function automatic logic [23:0] deb_to_cycles(input logic [2:0] code);
        return 24'(DEB_US[code] * CYC_PER_US);
    endfunction : deb_to_cycles

    // Pins 2 and 3 act as inputs unless their function selects open-drain or push-pull
    function automatic logic is_output(input logic [1:0] fn);
        return fn == FN_OPEN_DRAIN || fn == FN_PUSH_PULL;
    endfunction : is_output

    assign deb_limit = deb_to_cycles(lock_ctrl_q[DEB_LSB +: 3]); // RL8
    assign cfg[0] = pin_cfg_type'(in01_q[3:0]);
    assign cfg[1] = pin_cfg_type'(in01_q[7:4]);
    assign cfg[2] = pin_cfg_type'(pin23_q[3:0]);
    assign cfg[3] = pin_cfg_type'(pin23_q[7:4]);
    assign cfg[4] = pin_cfg_type'({in4_q[3:2], 2'h0});

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pin
            pin_debounce u_deb (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .pin_raw(pin_in[gi]),
                .debounce_on(cfg[gi].debounce_on),
                .polarity(cfg[gi].polarity),
                .limit(deb_limit),
                .level_active(level_now[gi])
            );
        end
    endgenerate

    // Register file and write lock
    always_comb begin
        logic wr;
        logic rd;
        logic [8:0] a;
        logic in_lock;
        logic clr_in;
        logic clr_fault;
        logic [4:0] new_in;
        logic [5:0] new_fault;
        wr = reg_req.write_en;
        rd = reg_req.read_en;
        a = reg_req.addr;
        in_lock = a >= LOCK_FIRST && a <= LOCK_LAST;
        mask_a_d = mask_a_q;
        fault_mask_d = fault_mask_q;
        lock_ctrl_d = lock_ctrl_q;
        in01_d = in01_q;
        pin23_d = pin23_q;
        in4_d = in4_q;
        vwr_d = 1'b0;
        vaddr_d = vaddr_q;
        vdata_d = vdata_q;
        rvalid_d = rd;
        rdata_d = 8'h00;
        clr_in = wr && a == ADDR_EVENT_A;
        clr_fault = wr && a == ADDR_EVENT_B;
        if (wr) begin
            case (a)
                ADDR_MASK_A: mask_a_d = reg_req.wdata & MASK_A_USED;
                ADDR_FAULT_MASK: fault_mask_d = reg_req.wdata & FAULT_MASK_USED;
                ADDR_LOCK_CTRL: lock_ctrl_d = {reg_req.wdata[7:3], 3'(reg_req.wdata[2:0])};
                ADDR_IN01_CFG: in01_d = reg_req.wdata;
                ADDR_PIN23_CFG: pin23_d = reg_req.wdata;
                ADDR_IN4_CFG: in4_d = reg_req.wdata & IN4_USED;
                default: begin
                    if (in_lock && !lock_ctrl_q[LOCK_BIT]) begin // RL5
                        vwr_d = 1'b1;
                        vaddr_d = a;
                        vdata_d = reg_req.wdata;
                    end
                end
            endcase
        end
        if (rd) begin
            case (a)
                ADDR_STATUS_A: rdata_d = {3'h0, level_q};
                ADDR_STATUS_B: rdata_d = {2'h0, fault_prev_q};
                ADDR_EVENT_A: rdata_d = {3'h0, event_in_q};
                ADDR_EVENT_B: rdata_d = {2'h0, event_fault_q};
                ADDR_MASK_A: rdata_d = mask_a_q;
                ADDR_FAULT_MASK: rdata_d = fault_mask_q;
                ADDR_LOCK_CTRL: rdata_d = lock_ctrl_q;
                ADDR_IN01_CFG: rdata_d = in01_q;
                ADDR_PIN23_CFG: rdata_d = pin23_q;
                ADDR_IN4_CFG: rdata_d = in4_q;
                default: rdata_d = 8'h00;
            endcase
        end
        // Events: level change into active state on inputs, status edges on faults
        level_d = level_now;
        fault_prev_d = fault_status;
        new_in = level_now & ~level_q;
        new_fault = {fault_status[5:2] & ~fault_prev_q[5:2], ~fault_status[1:0] & fault_prev_q[1:0]};
        new_fault[OVC_B_BIT] = new_fault[OVC_B_BIT] & ~fault_mask_q[OVC_B_BIT]; // RL2
        new_fault[OVC_A_BIT] = new_fault[OVC_A_BIT] & ~fault_mask_q[OVC_A_BIT]; // RL2
        // During a clearing write, new events wait one cycle in the pending set
        if (clr_in) begin
            event_in_d = (event_in_q & ~reg_req.wdata[4:0]) | pend_in_q; // RL16
            pend_in_d = new_in;
        end else begin
            event_in_d = event_in_q | pend_in_q | new_in;
            pend_in_d = 5'h00;
        end
        if (clr_fault) begin
            event_fault_d = (event_fault_q & ~reg_req.wdata[5:0]) | pend_fault_q; // RL16
            pend_fault_d = new_fault;
        end else begin
            event_fault_d = event_fault_q | pend_fault_q | new_fault;
            pend_fault_d = 6'h00;
        end
        // RL1 RL3 RL4 RL15
        irq_n_d = !(|(event_in_q & ~mask_a_q[4:0]) || |(event_fault_q & ~fault_mask_q[5:0]));
    end

    // Pin drivers and track enable
    always_comb begin
        logic lvl2;
        logic lvl3;
        lvl2 = pin23_q[3] ? pin23_q[2] : ~pin23_q[2]; // RL13
        lvl3 = pin23_q[7] ? pin23_q[6] : ~pin23_q[6]; // RL13
        p2o_d = 1'b0;
        p2e_d = 1'b0;
        p3o_d = 1'b0;
        p3e_d = 1'b0;
        if (is_output(pin23_q[1:0])) begin // RL12
            p2o_d = lvl2;
            p2e_d = pin23_q[1:0] == FN_PUSH_PULL || !lvl2;
        end
        if (is_output(pin23_q[5:4])) begin // RL12
            p3o_d = lvl3;
            p3e_d = pin23_q[5:4] == FN_PUSH_PULL || !lvl3;
        end
        trk_d = in01_q[1:0] == FN_TRACK && level_q[0]; // RL11
    end

    // Ramp step dividers, one per regulator
    always_comb begin
        logic [1:0] code [2];
        code[0] = lock_ctrl_q[RAMP_A_LSB +: 2]; // RL7
        code[1] = lock_ctrl_q[RAMP_B_LSB +: 2]; // RL6
        for (int r = 0; r < 2; r++) begin
            if (ramp_cnt_q[r] + 16'h0001 >= ns_to_cycles(code[r])) begin
                ramp_cnt_d[r] = 16'h0000;
                step_d[r] = 1'b1;
            end else begin
                ramp_cnt_d[r] = ramp_cnt_q[r] + 16'h0001;
                step_d[r] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_a_q <= MASK_A_RESET;
            fault_mask_q <= FAULT_MASK_RESET;
            lock_ctrl_q <= LOCK_CTRL_RESET;
            in01_q <= IN01_RESET;
            pin23_q <= PIN23_RESET;
            in4_q <= IN4_RESET;
            event_in_q <= 5'h00;
            event_fault_q <= 6'h00;
            pend_in_q <= 5'h00;
            pend_fault_q <= 6'h00;
            level_q <= 5'h00;
            fault_prev_q <= 6'h00;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            irq_n_q <= 1'b1;
            vwr_q <= 1'b0;
            vaddr_q <= 9'h000;
            vdata_q <= 8'h00;
            p2o_q <= 1'b0;
            p2e_q <= 1'b0;
            p3o_q <= 1'b0;
            p3e_q <= 1'b0;
            trk_q <= 1'b0;
            ramp_cnt_q[0] <= 16'h0000;
            ramp_cnt_q[1] <= 16'h0000;
            step_q <= 2'h0;
        end else begin
            mask_a_q <= mask_a_d;
            fault_mask_q <= fault_mask_d;
            lock_ctrl_q <= lock_ctrl_d;
            in01_q <= in01_d;
            pin23_q <= pin23_d;
            in4_q <= in4_d;
            event_in_q <= event_in_d;
            event_fault_q <= event_fault_d;
            pend_in_q <= pend_in_d;
            pend_fault_q <= pend_fault_d;
            level_q <= level_d;
            fault_prev_q <= fault_prev_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            irq_n_q <= irq_n_d;
            vwr_q <= vwr_d;
            vaddr_q <= vaddr_d;
            vdata_q <= vdata_d;
            p2o_q <= p2o_d;
            p2e_q <= p2e_d;
            p3o_q <= p3o_d;
            p3e_q <= p3e_d;
            trk_q <= trk_d;
            ramp_cnt_q[0] <= ramp_cnt_d[0];
            ramp_cnt_q[1] <= ramp_cnt_d[1];
            step_q <= step_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign volt_wr_en = vwr_q;
    assign volt_wr_addr = vaddr_q;
    assign volt_wr_data = vdata_q;
    assign pin2_out = p2o_q;
    assign pin2_oe = p2e_q;
    assign pin3_out = p3o_q;
    assign pin3_oe = p3e_q;
    assign track_enable = trk_q;
    assign ramp_step_a = step_q[0];
    assign ramp_step_b = step_q[1];
    assign interrupt_request_n = irq_n_q;
endmodule : gpio_irq_mask_control

// ### hdl/gpio_irq_pkg.sv
/*
 * Shared constants and carriers for the pin, mask and lock control block.
 * Assumes a 10 MHz system clock and a byte-wide register port in the device core.
 */
package gpio_irq_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam logic [8:0] ADDR_MASK_A = 9'h054;
    localparam logic [8:0] ADDR_FAULT_MASK = 9'h055;
    localparam logic [8:0] ADDR_LOCK_CTRL = 9'h056;
    localparam logic [8:0] ADDR_IN01_CFG = 9'h058;
    localparam logic [8:0] ADDR_PIN23_CFG = 9'h059;
    localparam logic [8:0] ADDR_IN4_CFG = 9'h05A;
    localparam logic [8:0] ADDR_EVENT_A = 9'h052;
    localparam logic [8:0] ADDR_EVENT_B = 9'h053;
    localparam logic [8:0] ADDR_STATUS_A = 9'h050;
    localparam logic [8:0] ADDR_STATUS_B = 9'h051;
    localparam logic [8:0] LOCK_FIRST = 9'h0D0;
    localparam logic [8:0] LOCK_LAST = 9'h14F;
    localparam logic [7:0] MASK_A_RESET = 8'h00;
    localparam logic [7:0] FAULT_MASK_RESET = 8'h00;
    localparam logic [7:0] LOCK_CTRL_RESET = 8'h00;
    localparam logic [7:0] IN01_RESET = 8'h00;
    localparam logic [7:0] PIN23_RESET = 8'h00;
    localparam logic [7:0] IN4_RESET = 8'h00;
    localparam logic [7:0] MASK_A_USED = 8'h5F;
    localparam logic [7:0] FAULT_MASK_USED = 8'h3F;
    localparam logic [7:0] IN4_USED = 8'h0F;
    localparam int LOCK_BIT = 7;
    localparam int RAMP_B_LSB = 5;
    localparam int RAMP_A_LSB = 3;
    localparam int DEB_LSB = 0;
    localparam int OVC_B_BIT = 5;
    localparam int OVC_A_BIT = 4;
    localparam logic [1:0] FN_INPUT = 2'h0;
    localparam logic [1:0] FN_TRACK = 2'h1;
    localparam logic [1:0] FN_OPEN_DRAIN = 2'h2;
    localparam logic [1:0] FN_PUSH_PULL = 2'h3;
    // Ramp step interval in ns per code, and debounce time in us per code
    localparam int RAMP_STEP_MV = 10;
    localparam int RAMP_NS [4] = '{4000, 2000, 1000, 500};
    localparam int DEB_US [8] = '{0, 100, 1000, 10000, 50000, 250000, 500000, 1000000};
    localparam int NS_PER_CYCLE = 1_000_000_000 / CLK_HZ;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic debounce_on;
        logic polarity;
        logic [1:0] function_sel;
    } pin_cfg_type;

    typedef struct packed {
        logic write_en;
        logic read_en;
        logic [8:0] addr;
        logic [7:0] wdata;
    } reg_req_type;
endpackage : gpio_irq_pkg

// ### hdl/pin_debounce.sv
/*
 * One input pin: two-stage synchroniser, stability filter and polarity.
 * Assumes the filter length arrives already converted to clock cycles.
 */
module pin_debounce
    import gpio_irq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pin and settings
    input wire logic pin_raw,
    input wire logic debounce_on,
    input wire logic polarity,
    input wire logic [23:0] limit,
    // Filtered level, active-true after polarity
    output logic level_active
);
    logic [SYNC_STAGES-1:0] sync_q, sync_d;
    logic stable_q, stable_d;
    logic [23:0] cnt_q, cnt_d;

    always_comb begin
        sync_d = {sync_q[0], pin_raw};
        stable_d = stable_q;
        cnt_d = cnt_q;
        if (!debounce_on || limit == 24'h000000) begin // RL9
            stable_d = sync_q[1];
            cnt_d = 24'h000000;
        end else if (sync_q[1] == stable_q) begin
            cnt_d = 24'h000000;
        end else if (cnt_q + 24'h000001 >= limit) begin // RL14
            stable_d = sync_q[1];
            cnt_d = 24'h000000;
        end else begin
            cnt_d = cnt_q + 24'h000001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle at the passive level of the reset polarity, so no false edge follows reset
            sync_q <= '1;
            stable_q <= 1'b1;
            cnt_q <= 24'h000000;
        end else begin
            sync_q <= sync_d;
            stable_q <= stable_d;
            cnt_q <= cnt_d;
        end
    end

    assign level_active = polarity ? stable_q : ~stable_q; // RL10
endmodule : pin_debounce

// ### tb/gpio_irq_checker_assertions.sv
/* Concurrent checks on the pin, mask and lock block.
   Assumes it is bound to the block top and sees one register request per cycle. */
module gpio_irq_checker
    import gpio_irq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire reg_req_type reg_req,
    input wire logic reg_rvalid,
    input wire logic volt_wr_en,
    input wire logic [8:0] volt_wr_addr,
    input wire logic [7:0] volt_wr_data,
    // Outputs
    input wire logic pin2_out,
    input wire logic pin2_oe,
    input wire logic track_enable,
    input wire logic ramp_step_a,
    input wire logic ramp_step_b,
    input wire logic interrupt_request_n
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [8:0] SHD_ADDR [4] = '{ADDR_MASK_A, ADDR_FAULT_MASK, ADDR_LOCK_CTRL, ADDR_PIN23_CFG};
    logic [7:0] shd_q [4];
    logic [7:0] shd_d [4];
    logic in_rng;
    assign in_rng = reg_req.write_en && reg_req.addr >= LOCK_FIRST && reg_req.addr <= LOCK_LAST;
    always_comb begin
        shd_d = shd_q;
        for (int i = 0; i < 4; i++) begin
            if (reg_req.write_en && reg_req.addr == SHD_ADDR[i]) begin
                shd_d[i] = reg_req.wdata;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shd_q <= '{default: 8'h00};
        end else begin
            shd_q <= shd_d;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    lock_drop_a: assert property (in_rng && shd_q[2][LOCK_BIT] |=> !volt_wr_en)
        else $error("locked write forwarded");
    lock_pass_a: assert property (in_rng && !shd_q[2][LOCK_BIT] |=> volt_wr_en &&
        volt_wr_addr == $past(reg_req.addr) && volt_wr_data == $past(reg_req.wdata))
        else $error("open write not forwarded");
    read_ans_a: assert property (reg_req.read_en |=> reg_rvalid)
        else $error("read not answered");
    ramp_gap_a: assert property (ramp_step_a |=> !ramp_step_a [*4])
        else $error("ramp a steps too close");
    ramp_gap_b: assert property (ramp_step_b |=> !ramp_step_b [*4])
        else $error("ramp b steps too close");
    all_masked_a: assert property ((shd_q[0][4:0] == 5'h1F && shd_q[1][5:0] == 6'h3F) [*2]
        |-> interrupt_request_n) else $error("interrupt while all masked");
    input_quiet_a: assert property ((shd_q[3][1:0] == FN_INPUT) [*3] |-> !pin2_oe)
        else $error("input pin driven");
    drain_low_a: assert property ((shd_q[3][1:0] == FN_OPEN_DRAIN) [*3] |-> !(pin2_oe && pin2_out))
        else $error("open drain drives high");
    cover property (volt_wr_en);
    cover property (!interrupt_request_n);
    cover property (track_enable);
endmodule : gpio_irq_checker

// ### tb/gpio_irq_mask_control_bench.sv
/* Self-checking bench: registers through the host model, pins and faults driven
   at falling edges. Assumes the ramp step counters run freely. */
module gpio_irq_mask_control_bench
    import gpio_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] pin_drv = 5'h1F;
    logic [5:0] fault_status = 6'h03;
    logic [4:0] pin_in;
    reg_req_type reg_req;
    logic [7:0] reg_rdata, volt_wr_data, v;
    logic [8:0] volt_wr_addr;
    logic reg_rvalid, volt_wr_en, pin2_out, pin2_oe, pin3_out, pin3_oe;
    logic track_enable, ramp_step_a, ramp_step_b, interrupt_request_n;
    int err_count = 0;
    int total_checks = 0;
    int ticks = 0;
    // Pins 2 and 3 see their own drive when enabled, else the bench pull level
    assign pin_in = {pin_drv[4], pin3_oe ? pin3_out : pin_drv[3], pin2_oe ? pin2_out : pin_drv[2], pin_drv[1:0]};
    gpio_irq_mask_control DUT (.sys_clk, .rst_n, .reg_req, .reg_rdata, .reg_rvalid, .volt_wr_en,
        .volt_wr_addr, .volt_wr_data, .pin_in, .pin2_out, .pin2_oe, .pin3_out, .pin3_oe,
        .track_enable, .fault_status, .ramp_step_a, .ramp_step_b, .interrupt_request_n);
    host_model host (.sys_clk, .reg_req, .reg_rdata, .reg_rvalid);
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        ticks++;
        if (ticks == 30000) begin
            err_count++;
            close_out();
        end
    end
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (e !== s) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask : ck
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    task automatic clr();
        host.clr(ADDR_EVENT_A);
        host.clr(ADDR_EVENT_B);
        cyc(2);
        ck("irq idle", 1'b1, interrupt_request_n);
    endtask : clr
    task automatic t_regs();
        logic [8:0] a [6] = '{ADDR_FAULT_MASK, ADDR_LOCK_CTRL, ADDR_IN01_CFG, ADDR_PIN23_CFG, ADDR_IN4_CFG, 9'h05B};
        logic [7:0] m [6] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h00};
        for (int i = 0; i < 6; i++) begin
            host.rd(a[i], v);
            ck("reset", 8'h00, v);
            host.wr(a[i], 8'hFF);
            host.rd(a[i], v);
            ck("readback", m[i], v);
            host.wr(a[i], 8'h00);
        end
        cyc(8);
        clr();
        $display("regs done");
    endtask : t_regs
    task automatic t_lock();
        logic [8:0] a [6] = '{LOCK_FIRST, LOCK_LAST, 9'h150, 9'h100, LOCK_FIRST, LOCK_LAST};
        logic [5:0] e = 6'b100011;
        for (int i = 0; i < 6; i++) begin
            if (i == 3) host.wr(ADDR_LOCK_CTRL, 8'h80);
            if (i == 5) host.wr(ADDR_LOCK_CTRL, 8'h00);
            host.wr(a[i], 8'h30 + i[7:0]);
            ck("volt_wr_en", e[i], volt_wr_en);
            if (e[i]) ck("volt_wr", {a[i], 8'h30 + i[7:0]}, {volt_wr_addr, volt_wr_data});
        end
        $display("lock done");
    endtask : t_lock
    task automatic t_fault();
        for (int i = 0; i < 6; i++) begin
            for (int m = 0; m < 2; m++) begin
                host.wr(ADDR_FAULT_MASK, m ? 8'h01 << i : 8'h00);
                fault_status[i] = ~fault_status[i];
                cyc(4);
                ck("irq", m, interrupt_request_n);
                host.rd(ADDR_EVENT_B, v);
                ck("fault event", (m && i >= OVC_A_BIT) ? 8'h00 : 8'h01 << i, v);
                fault_status[i] = ~fault_status[i];
                cyc(2);
                clr();
            end
        end
        // All sources masked, faults change in the very cycle of a clearing write
        host.wr(ADDR_MASK_A, 8'h1F);
        host.wr(ADDR_FAULT_MASK, 8'h3F);
        fork
            host.wr(ADDR_EVENT_B, 8'h3F);
            begin
                @(negedge sys_clk);
                fault_status = 6'h3C;
            end
        join
        cyc(4);
        ck("irq all masked", 1'b1, interrupt_request_n);
        host.rd(ADDR_EVENT_B, v);
        ck("event in clear", 8'h0F, v);
        fault_status = 6'h03;
        cyc(2);
        clr();
        host.wr(ADDR_MASK_A, 8'h00);
        host.wr(ADDR_FAULT_MASK, 8'h00);
        $display("fault done");
    endtask : t_fault
    task automatic gap(input bit b, output int n);
        int k;
        k = 0;
        while ((b ? ramp_step_b : ramp_step_a) !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        cyc(1);
        n = 1;
        while ((b ? ramp_step_b : ramp_step_a) !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
    endtask : gap
    task automatic t_ramp();
        int n;
        for (int c = 0; c < 4; c++) begin
            host.wr(ADDR_LOCK_CTRL, {1'b0, c[1:0], c[1:0], 3'h0});
            for (int b = 0; b < 2; b++) begin
                // The first gap after a code change may still run at the old rate
                gap(b[0], n);
                gap(b[0], n);
                ck("ramp gap", RAMP_NS[c] / NS_PER_CYCLE, n);
            end
        end
        $display("ramp done");
    endtask : t_ramp
    task automatic t_pins();
        logic [3:0] cf [10] = '{4'hF, 4'h7, 4'hB, 4'h3, 4'hA, 4'h6, 4'h2, 4'hE, 4'hC, 4'h1};
        logic [1:0] ex [10] = '{2'h3, 2'h2, 2'h2, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};
        for (int i = 0; i < 10; i++) begin
            host.wr(ADDR_PIN23_CFG, {cf[i], cf[i]});
            cyc(3);
            ck("pin2", ex[i], {pin2_oe, pin2_oe & pin2_out});
            ck("pin3", ex[i], {pin3_oe, pin3_oe & pin3_out});
        end
        host.wr(ADDR_PIN23_CFG, 8'h00);
        cyc(6);
        clr();
        $display("pins done");
    endtask : t_pins
    task automatic t_track();
        logic [7:0] cf [5] = '{8'h05, 8'h01, 8'h00, 8'h02, 8'h05};
        logic [4:0] pv = 5'b00001;
        logic [4:0] ex = 5'b00011;
        for (int i = 0; i < 5; i++) begin
            host.wr(ADDR_IN01_CFG, cf[i]);
            pin_drv[0] = pv[i];
            cyc(6);
            ck("track_enable", ex[i], track_enable);
        end
        pin_drv[0] = 1'b1;
        host.wr(ADDR_IN01_CFG, 8'h00);
        cyc(6);
        clr();
        $display("track done");
    endtask : t_track
    task automatic t_deb();
        int lim;
        lim = DEB_US[1] * CYC_PER_US;
        host.wr(ADDR_LOCK_CTRL, 8'h01);
        host.wr(ADDR_IN01_CFG, 8'h80);
        pin_drv[1] = 1'b0;
        cyc(lim / 2);
        pin_drv[1] = 1'b1;
        cyc(20);
        ck("irq glitch", 1'b1, interrupt_request_n);
        pin_drv[1] = 1'b0;
        cyc(lim - 10);
        ck("irq early", 1'b1, interrupt_request_n);
        cyc(20);
        ck("irq late", 1'b0, interrupt_request_n);
        pin_drv[1] = 1'b1;
        host.wr(ADDR_IN01_CFG, 8'h00);
        host.wr(ADDR_MASK_A, 8'h02);
        cyc(6);
        clr();
        pin_drv[1] = 1'b0;
        cyc(6);
        ck("irq masked", 1'b1, interrupt_request_n);
        host.wr(ADDR_MASK_A, 8'h00);
        cyc(2);
        ck("irq unmasked", 1'b0, interrupt_request_n);
        pin_drv[1] = 1'b1;
        cyc(6);
        clr();
        $display("debounce done");
    endtask : t_deb
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    initial begin
        cyc(2);
        rst_n = 1'b1;
        cyc(8);
        clr();
        t_regs();
        t_lock();
        t_fault();
        t_ramp();
        t_pins();
        t_track();
        t_deb();
        close_out();
    end
endmodule : gpio_irq_mask_control_bench
bind gpio_irq_mask_control gpio_irq_checker chk_i (.sys_clk, .rst_n, .reg_req, .reg_rvalid,
    .volt_wr_en, .volt_wr_addr, .volt_wr_data, .pin2_out, .pin2_oe, .track_enable,
    .ramp_step_a, .ramp_step_b, .interrupt_request_n);

// ### tb/host_model.sv
/* Host processor model on the byte register port.
   Assumes callers enter its tasks at a falling edge of sys_clk. */
module host_model
    import gpio_irq_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Register port
    output reg_req_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial reg_req = '0;
    // Released fields show the inverse, so a stale value is never mistaken for a live one
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_req = '{1'b1, 1'b0, a, d};
        @(negedge sys_clk);
        reg_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_req = '{1'b0, 1'b1, a, 8'h5A};
        @(negedge sys_clk);
        reg_req = '{1'b0, 1'b0, ~a, 8'hA5};
        d = reg_rvalid ? reg_rdata : 8'hXX;
    endtask : rd
    task automatic clr(input logic [8:0] a);
        logic [7:0] v;
        rd(a, v);
        wr(a, v);
    endtask : clr
endmodule : host_model
